// [msi_pkg.sv]
// Package of constants, codes and helpers for the motion start interlock
// Behaviour
// - Move target outside -536870912..+536870911 gives axis status code 76
// - Move command 27h during host first scan gives axis status code 77
// - Execute during homing gives axis code 80; host waits or aborts homing
// - Execute during jog gives axis code 81; jog requests cleared first
// - Execute while velocity move 22h runs gives axis code 82
// - Execute while force 34h or 24h active gives axis code 83
// - Execute while program-running status set and axis not moving gives axis code 84
// - Execute during abort, or while moving with program running, gives axis code 85
// - Execute without position valid gives axis code 86
// - Execute without drive enabled gives axis code 87
// - Continuous move sync block reached before partner gives code 8C
// - Jump onto sync-tagged move before partner gives axis code 8D
// - Flash programming failure gives module status code 90
// - Local logic halt write gives module fast-stop code 91
// - Local logic run over 300 us gives module fast-stop code 92
// - Local logic divide or modulus by zero gives module code 93
// - Execute during host first scan is rejected with module code 70
// - Execute naming undefined program gives module status code 75
`default_nettype none
package msi_pkg;

  // ==========================================================
  // Error codes
  localparam logic [7:0] ERR_FIRST_EXEC  = 8'h70;
  localparam logic [7:0] ERR_BAD_PROG    = 8'h75;
  localparam logic [7:0] ERR_POS_RANGE   = 8'h76;
  localparam logic [7:0] ERR_MOVE_FIRST  = 8'h77;
  localparam logic [7:0] ERR_HOMING      = 8'h80;
  localparam logic [7:0] ERR_JOG         = 8'h81;
  localparam logic [7:0] ERR_VEL_MOVE    = 8'h82;
  localparam logic [7:0] ERR_FORCE       = 8'h83;
  localparam logic [7:0] ERR_PROG_ACTIVE = 8'h84;
  localparam logic [7:0] ERR_ABORT       = 8'h85;
  localparam logic [7:0] ERR_POS_INVALID = 8'h86;
  localparam logic [7:0] ERR_DRIVE_OFF   = 8'h87;
  localparam logic [7:0] ERR_SYNC_CONTINUOUS_MOVE  = 8'h8c;
  localparam logic [7:0] ERR_SYNC_JUMP   = 8'h8d;
  localparam logic [7:0] ERR_FLASH       = 8'h90;
  localparam logic [7:0] ERR_LL_HALT     = 8'h91;
  localparam logic [7:0] ERR_LL_TIMEOUT  = 8'h92;
  localparam logic [7:0] ERR_LL_DIV_ZERO = 8'h93;

  // ==========================================================
  // Host command codes
  localparam logic [7:0] CMD_MOVE_POS    = 8'h27;

  // ==========================================================
  // Register offsets and fields
  localparam logic [7:0] OFS_MOD_STATUS  = 8'h00;
  localparam logic [7:0] OFS_AXIS_BASE   = 8'h04;
  localparam logic [7:0] OFS_ACK         = 8'h20;
  localparam logic [7:0] OFS_PROG_MASK   = 8'h24;
  localparam int         FLD_PRESENT     = 8;
  localparam int         FLD_FAST_STOP   = 9;
  localparam logic [15:0] PROG_MASK_RST  = 16'h0000;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int LL_BUDGET_US   = 300;
  localparam int LL_BUDGET_CYC  = (LL_BUDGET_US * 1000) / CLK_PERIOD_NS;

  // Signed 30-bit target range check
  function automatic logic pos_in_range(input logic [31:0] pos);
    pos_in_range = (pos[31:29] == 3'h0) || (pos[31:29] == 3'h7);
  endfunction : pos_in_range

endpackage : msi_pkg
`default_nettype wire

// [msi_ahb_slave.sv]
// AHB-Lite slave front end with one wait state per transfer
`default_nettype none
module msi_ahb_slave (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  // Register side
  input  wire logic [31:0] rd_data,
  output logic [7:0]       reg_addr,
  output logic             reg_wr,
  output logic             reg_rd
);
  logic        busy_r, busy_nxt;
  logic        write_r, write_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic        ready_r, ready_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // ==========================================================
  // Address and data phase
  always_comb begin
    busy_nxt  = 1'b0;
    write_nxt = write_r;
    addr_nxt  = addr_r;
    ready_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (busy_r) begin
      if (!write_r) begin
        rdata_nxt = rd_data;
      end
    end else if (hsel && htrans[1] && hready) begin
      busy_nxt  = 1'b1;
      write_nxt = hwrite;
      addr_nxt  = {haddr[7:2], 2'b00};
      ready_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r  <= 1'b0;
      write_r <= 1'b0;
      addr_r  <= 8'h00;
      ready_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      busy_r  <= busy_nxt;
      write_r <= write_nxt;
      addr_r  <= addr_nxt;
      ready_r <= ready_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hreadyout = ready_r;
  assign hrdata    = rdata_r;
  assign reg_addr  = addr_r;
  assign reg_wr    = busy_r & write_r;
  assign reg_rd    = busy_r & ~write_r;

endmodule : msi_ahb_slave
`default_nettype wire

// [msi_budget_timer.sv]
// Execution budget timer for one local logic run
`default_nettype none
module msi_budget_timer #(
  parameter int LIMIT_CYC = 12000
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Run control
  input  wire logic run_start,
  input  wire logic run_done,
  output logic      overrun
);
  logic        active_r, active_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic        over_r, over_nxt;

  // ==========================================================
  // Count cycles while a run is active
  always_comb begin
    active_nxt = active_r;
    cnt_nxt    = cnt_r;
    over_nxt   = 1'b0;
    if (run_start) begin
      active_nxt = 1'b1;
      cnt_nxt    = 32'h0000_0001;
    end else if (active_r) begin
      if (run_done) begin
        active_nxt = 1'b0;
      end else if (cnt_r >= 32'(LIMIT_CYC)) begin
        active_nxt = 1'b0;
        over_nxt   = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= 1'b0;
      cnt_r    <= 32'h0000_0000;
      over_r   <= 1'b0;
    end else begin
      active_r <= active_nxt;
      cnt_r    <= cnt_nxt;
      over_r   <= over_nxt;
    end
  end

  assign overrun = over_r;

endmodule : msi_budget_timer
`default_nettype wire

// [msi_interlock.sv]
// Top level: start interlocks, error latching and register file
`default_nettype none
module msi_interlock
  import msi_pkg::*;
#(
  parameter int NUM_AXES  = 2,
  parameter int PROG_BITS = 4,
  parameter int LL_BUDGET = msi_pkg::LL_BUDGET_CYC
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // AHB-Lite
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Host scan and commands
  input  wire logic                  first_scan,
  input  wire logic [NUM_AXES-1:0]   exec_req,
  input  wire logic [PROG_BITS-1:0]  exec_prog,
  input  wire logic [NUM_AXES-1:0]   cmd_valid,
  input  wire logic [7:0]            host_command_word,
  input  wire logic [31:0]           cmd_position,
  // Axis status
  input  wire logic [NUM_AXES-1:0]   homing_active,
  input  wire logic [NUM_AXES-1:0]   jog_active,
  input  wire logic [NUM_AXES-1:0]   vel_move_active,
  input  wire logic [NUM_AXES-1:0]   force_active,
  input  wire logic [NUM_AXES-1:0]   prog_running,
  input  wire logic [NUM_AXES-1:0]   abort_req,
  input  wire logic [NUM_AXES-1:0]   moving,
  input  wire logic [NUM_AXES-1:0]   pos_valid,
  input  wire logic [NUM_AXES-1:0]   drive_enabled,
  // Synchronisation blocks
  input  wire logic [NUM_AXES-1:0]   continuous_move_sync,
  input  wire logic [NUM_AXES-1:0]   jump_sync,
  input  wire logic [NUM_AXES-1:0]   partner_at_sync,
  // Module events
  input  wire logic                  flash_fail,
  input  wire logic                  ll_halt_write,
  input  wire logic                  ll_run_start,
  input  wire logic                  ll_run_done,
  input  wire logic                  ll_div_op,
  input  wire logic [31:0]           ll_divisor,
  // Results
  output logic [NUM_AXES-1:0]        exec_start,
  output logic [NUM_AXES-1:0]        move_accept,
  output logic [NUM_AXES-1:0]        fast_stop,
  output logic                       err_present
);
  import msi_pkg::*;

  logic [7:0]           reg_addr;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [31:0]          rd_data;
  logic                 ll_overrun;

  logic [7:0]           mod_code_r, mod_code_nxt;
  logic                 mod_flag_r, mod_flag_nxt;
  logic [7:0]           ax_code_r   [NUM_AXES];
  logic [7:0]           ax_code_nxt [NUM_AXES];
  logic [NUM_AXES-1:0]  ax_flag_r, ax_flag_nxt;
  logic [NUM_AXES-1:0]  stop_r, stop_nxt;
  logic [NUM_AXES-1:0]  start_r, start_nxt;
  logic [NUM_AXES-1:0]  accept_r, accept_nxt;
  logic                 present_r, present_nxt;
  logic                 hresp_r;
  logic [15:0]          prog_mask_r, prog_mask_nxt;

  // ==========================================================
  // Bus front end
  msi_ahb_slave u_bus (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .rd_data   (rd_data),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    ()
  );

  // ==========================================================
  // Local logic budget
  // budget overrun detect
  msi_budget_timer #(
    .LIMIT_CYC (LL_BUDGET)
  ) u_timer (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .run_start (ll_run_start),
    .run_done  (ll_run_done),
    .overrun   (ll_overrun)
  );

  // ==========================================================
  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    if (reg_addr == OFS_MOD_STATUS) begin
      rd_data[7:0]          = mod_code_r;
      rd_data[FLD_PRESENT]  = mod_flag_r;
      rd_data[FLD_FAST_STOP] = |stop_r;
    end else if (reg_addr == OFS_PROG_MASK) begin
      rd_data[15:0] = prog_mask_r;
    end
    for (int a = 0; a < NUM_AXES; a++) begin
      if (reg_addr == 8'(OFS_AXIS_BASE + 4 * a)) begin
        rd_data[7:0]         = ax_code_r[a];
        rd_data[FLD_PRESENT] = ax_flag_r[a];
        rd_data[FLD_FAST_STOP] = stop_r[a];
      end
    end
  end

  // ==========================================================
  // Error detection and latching
  always_comb begin
    logic       mod_hit;
    logic       mod_fast;
    logic [7:0] mod_err;
    logic       ax_hit;
    logic [7:0] ax_err;
    logic       ack_wr;
    mod_hit  = 1'b0;
    mod_fast = 1'b0;
    mod_err  = 8'h00;
    ax_hit   = 1'b0;
    ax_err   = 8'h00;
    ack_wr   = reg_wr && (reg_addr == OFS_ACK);
    prog_mask_nxt = prog_mask_r;
    if (reg_wr && (reg_addr == OFS_PROG_MASK)) begin
      prog_mask_nxt = hwdata[15:0];
    end
    mod_code_nxt = mod_code_r;
    mod_flag_nxt = mod_flag_r;
    stop_nxt     = stop_r;
    start_nxt    = '0;
    accept_nxt   = '0;
    ax_flag_nxt  = ax_flag_r;
    if (ack_wr && hwdata[0]) begin
      mod_flag_nxt = 1'b0;
      stop_nxt     = '0;
    end
    if ((|exec_req) && first_scan) begin
      mod_hit = 1'b1;
      mod_err = ERR_FIRST_EXEC;
    end else if ((|exec_req) && !prog_mask_r[exec_prog]) begin
      mod_hit = 1'b1;
      mod_err = ERR_BAD_PROG;
    end
    if (flash_fail) begin
      mod_hit = 1'b1;
      mod_err = ERR_FLASH;
    end
    if (ll_div_op && (ll_divisor == 32'h0000_0000)) begin
      mod_hit  = 1'b1;
      mod_fast = 1'b1;
      mod_err  = ERR_LL_DIV_ZERO;
    end
    if (ll_overrun) begin
      mod_hit  = 1'b1;
      mod_fast = 1'b1;
      mod_err  = ERR_LL_TIMEOUT;
    end
    if (ll_halt_write) begin
      mod_hit  = 1'b1;
      mod_fast = 1'b1;
      mod_err  = ERR_LL_HALT;
    end
    if (mod_hit) begin
      mod_code_nxt = mod_err;
      mod_flag_nxt = 1'b1;
    end
    if (mod_fast) begin
      stop_nxt = '1;
    end
    for (int a = 0; a < NUM_AXES; a++) begin
      ax_code_nxt[a] = ax_code_r[a];
      ax_hit = 1'b0;
      ax_err = 8'h00;
      if (ack_wr && hwdata[1 + a]) begin
        ax_flag_nxt[a] = 1'b0;
      end
      if (cmd_valid[a] && (host_command_word == CMD_MOVE_POS)) begin
        if (first_scan) begin
          ax_hit = 1'b1;
          ax_err = ERR_MOVE_FIRST;
        end else if (!pos_in_range(cmd_position)) begin
          ax_hit = 1'b1;
          ax_err = ERR_POS_RANGE;
        end else begin
          accept_nxt[a] = 1'b1;
        end
      end
      if (exec_req[a] && !first_scan && prog_mask_r[exec_prog]) begin
        ax_hit = 1'b1;
        if (homing_active[a]) begin
          ax_err = ERR_HOMING;
        end else if (jog_active[a]) begin
          ax_err = ERR_JOG;
        end else if (vel_move_active[a]) begin
          ax_err = ERR_VEL_MOVE;
        end else if (force_active[a]) begin
          ax_err = ERR_FORCE;
        end else if (abort_req[a] || (moving[a] && prog_running[a])) begin
          ax_err = ERR_ABORT;
        end else if (prog_running[a]) begin
          ax_err = ERR_PROG_ACTIVE;
        end else if (!pos_valid[a]) begin
          ax_err = ERR_POS_INVALID;
        end else if (!drive_enabled[a]) begin
          ax_err = ERR_DRIVE_OFF;
        end else begin
          ax_hit = 1'b0;
          start_nxt[a] = !mod_fast && !stop_r[a];
        end
      end
      if (continuous_move_sync[a] && !partner_at_sync[a]) begin
        ax_hit = 1'b1;
        ax_err = ERR_SYNC_CONTINUOUS_MOVE;
      end
      if (jump_sync[a] && !partner_at_sync[a]) begin
        ax_hit = 1'b1;
        ax_err = ERR_SYNC_JUMP;
      end
      if (ax_hit) begin
        ax_code_nxt[a] = ax_err;
        ax_flag_nxt[a] = 1'b1;
      end
    end
    present_nxt = mod_flag_nxt | (|ax_flag_nxt);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_code_r  <= 8'h00;
      mod_flag_r  <= 1'b0;
      ax_flag_r   <= '0;
      stop_r      <= '0;
      start_r     <= '0;
      accept_r    <= '0;
      present_r   <= 1'b0;
      hresp_r     <= 1'b0;
      prog_mask_r <= PROG_MASK_RST;
      for (int a = 0; a < NUM_AXES; a++) begin
        ax_code_r[a] <= 8'h00;
      end
    end else begin
      mod_code_r  <= mod_code_nxt;
      mod_flag_r  <= mod_flag_nxt;
      ax_flag_r   <= ax_flag_nxt;
      stop_r      <= stop_nxt;
      start_r     <= start_nxt;
      accept_r    <= accept_nxt;
      present_r   <= present_nxt;
      hresp_r     <= 1'b0;
      prog_mask_r <= prog_mask_nxt;
      for (int a = 0; a < NUM_AXES; a++) begin
        ax_code_r[a] <= ax_code_nxt[a];
      end
    end
  end

  assign hresp       = hresp_r;
  assign exec_start  = start_r;
  assign move_accept = accept_r;
  assign fast_stop   = stop_r;
  assign err_present = present_r;

endmodule : msi_interlock
`default_nettype wire

// [msi_interlock_checker.sv]
// Concurrent checks on the interlock top-level ports
`default_nettype none
module msi_interlock_checker
  import msi_pkg::*;
#(
  parameter int NUM_AXES = 2
) (
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rst_n,
  // Bus
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic                hreadyout,
  // Host and events
  input wire logic                first_scan,
  input wire logic [NUM_AXES-1:0] exec_req,
  input wire logic [NUM_AXES-1:0] homing_active,
  input wire logic [NUM_AXES-1:0] cmd_valid,
  input wire logic [7:0]          host_command_word,
  input wire logic [31:0]         cmd_position,
  input wire logic                ll_halt_write,
  input wire logic                ll_div_op,
  input wire logic [31:0]         ll_divisor,
  // Results
  input wire logic [NUM_AXES-1:0] exec_start,
  input wire logic [NUM_AXES-1:0] move_accept,
  input wire logic [NUM_AXES-1:0] fast_stop,
  input wire logic                err_present
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic mv_bad;
  logic ack_r;
  assign take   = hsel && htrans[1] && hready;
  assign mv_bad = cmd_valid[0] && (host_command_word == CMD_MOVE_POS) &&
                  !(cmd_position[31:29] == 3'h0 || cmd_position[31:29] == 3'h7);
  // ===========================================================
  // Ack data phase marker
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take && hwrite && (haddr[7:0] == OFS_ACK);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ===========================================================
  // Properties
  property p_wait;
    take |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait state wrong");
  property p_homing;
    exec_req[0] && homing_active[0] |=> !exec_start[0] && err_present;
  endproperty
  a_homing: assert property (p_homing) else $error("start in homing");
  property p_first_exec;
    first_scan && (exec_req != '0) |=> (exec_start == '0) && err_present;
  endproperty
  a_first_exec: assert property (p_first_exec)
    else $error("first exec");
  property p_range;
    mv_bad |=> !move_accept[0] && err_present;
  endproperty
  a_range: assert property (p_range) else $error("range move taken");
  property p_halt;
    ll_halt_write |=> (&fast_stop) && err_present;
  endproperty
  a_halt: assert property (p_halt) else $error("halt no stop");
  property p_div_zero;
    ll_div_op && (ll_divisor == 32'h0) |=> &fast_stop;
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("div zero");
  property p_flag_hold;
    err_present && !ack_r |=> err_present;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_stop_block;
    exec_req[0] && fast_stop[0] |=> !exec_start[0];
  endproperty
  a_stop_block: assert property (p_stop_block)
    else $error("start in stop");
endmodule : msi_interlock_checker
bind msi_interlock msi_interlock_checker #(.NUM_AXES(NUM_AXES))
  msi_interlock_checker_inst (.core_clk, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .first_scan, .exec_req, .homing_active,
  .cmd_valid, .host_command_word, .cmd_position, .ll_halt_write, .ll_div_op,
  .ll_divisor, .exec_start, .move_accept, .fast_stop, .err_present);
`default_nettype wire

// [msi_host_model.sv]
// Host controller model driving axis status and execute requests
`default_nettype none
module msi_host_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Bench control
  input  wire logic [3:0] cond,
  input  wire logic       fire,
  // Host side
  output logic [1:0]      exec_req,
  output logic [1:0]      homing_active,
  output logic [1:0]      jog_active,
  output logic [1:0]      vel_move_active,
  output logic [1:0]      force_active,
  output logic [1:0]      prog_running,
  output logic [1:0]      abort_req,
  output logic [1:0]      moving,
  output logic [1:0]      pos_valid,
  output logic [1:0]      drive_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] c_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_r      <= 4'h0;
      exec_req <= 2'h0;
    end else begin
      c_r      <= cond;
      exec_req <= {1'b0, fire};
    end
  end
  // homing and jog off when idle
  assign homing_active   = {1'b0, c_r == 4'h1};
  assign jog_active      = {1'b0, c_r == 4'h2};
  assign vel_move_active = {1'b0, c_r == 4'h3};
  assign force_active    = {1'b0, c_r == 4'h4};
  assign abort_req       = {1'b0, c_r == 4'h5};
  assign prog_running    = {1'b0, c_r == 4'h6 || c_r == 4'h9};
  assign moving          = {1'b0, c_r == 4'h9};
  assign pos_valid       = {1'b1, c_r != 4'h7};
  assign drive_enabled   = {1'b1, c_r != 4'h8};
endmodule : msi_host_model
`default_nettype wire

// [msi_tb.sv]
// Self-checking bench for the motion start interlock
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import msi_pkg::*;
  localparam int LLB = 20;
  logic        core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic        first_scan, fire, flash_fail, ll_halt_write, ll_run_start;
  logic        ll_run_done, ll_div_op, err_present;
  logic [31:0] haddr, hwdata, hrdata, cmd_position, ll_divisor, q, e, pos;
  logic [1:0]  htrans, exec_req, cmd_valid, homing_active, jog_active;
  logic [1:0]  vel_move_active, force_active, prog_running, abort_req, moving;
  logic [1:0]  pos_valid, drive_enabled, continuous_move_sync, jump_sync;
  logic [1:0]  partner_at_sync, exec_start, move_accept, fast_stop;
  logic [2:0]  hsize;
  logic [3:0]  exec_prog, cond;
  logic [7:0]  host_command_word;
  int          err_count, compares, starts, moves, exp_starts, exp_moves, sp;
  logic [7:0]  ax_code [10] = '{8'h00, 8'h80, 8'h81, 8'h82, 8'h83, 8'h85,
                                8'h84, 8'h86, 8'h87, 8'h85};
  logic [31:0] mod_exp [6] = '{32'h190, 32'h391, 32'h393, 32'h0,
                               32'h392, 32'h0};
  logic [31:0] edge_pos [4] = '{32'h1fffffff, 32'h20000000, 32'he0000000,
                                32'hdfffffff};
  assign hready = hreadyout;
  msi_interlock #(.LL_BUDGET(LLB)) msi_interlock_inst (.core_clk, .rst_n,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .first_scan, .exec_req, .exec_prog, .cmd_valid,
    .host_command_word, .cmd_position, .homing_active, .jog_active,
    .vel_move_active, .force_active, .prog_running, .abort_req, .moving,
    .pos_valid, .drive_enabled, .continuous_move_sync, .jump_sync,
    .partner_at_sync, .flash_fail, .ll_halt_write, .ll_run_start, .ll_run_done,
    .ll_div_op, .ll_divisor, .exec_start, .move_accept, .fast_stop,
    .err_present);
  msi_host_model msi_host_model_inst (.core_clk, .rst_n, .cond, .fire,
    .exec_req, .homing_active, .jog_active, .vel_move_active, .force_active,
    .prog_running, .abort_req, .moving, .pos_valid, .drive_enabled);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (exec_start[0] === 1'b1) starts++;
    if (move_accept[0] === 1'b1) moves++;
  end
  // ===========================================================
  // Tasks
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_cnt(input int got, input int exp);
    compares++;
    if (got != exp) begin
      err_count++;
      $display("ERROR %0t count got %0d exp %0d", $time, got, exp);
    end
  endtask : cmp_cnt
  task automatic wait_rdy;
    do begin
      @(posedge core_clk);
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus
  task automatic chk(input logic [7:0] a, input logic [31:0] x,
                     input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    cmp_reg(q & m, x & m);
    cmp_reg({31'h0, hresp}, 32'h0);
  endtask : chk
  task automatic exec(input logic [3:0] c, input logic [3:0] p);
    cond      <= c;
    exec_prog <= p;
    fire      <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : exec
  task automatic wrap_up;
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // ===========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("ERROR %0t watchdog", $time);
    wrap_up();
  end
  // ===========================================================
  // Main sequence
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, first_scan, exec_prog, cmd_valid,
     host_command_word, cmd_position, continuous_move_sync, jump_sync,
     partner_at_sync, flash_fail, ll_halt_write, ll_run_start, ll_run_done,
     ll_div_op, ll_divisor, cond, fire, rst_n} = '0;
    hsize = 3'h2;
    void'($urandom(32'hcda4c406));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(OFS_MOD_STATUS, 32'h0, 32'hffffffff);
    chk(OFS_AXIS_BASE, 32'h0, 32'hffffffff);
    chk(OFS_PROG_MASK, {16'h0, PROG_MASK_RST}, 32'hffffffff);
    chk(8'h30, 32'h0, 32'hffffffff);
    bus(1'b1, OFS_PROG_MASK, 32'h6);
    chk(OFS_PROG_MASK, 32'h6, 32'hffffffff);
    first_scan <= 1'b1;
    exec(4'h0, 4'h1);
    first_scan <= 1'b0;
    chk(OFS_MOD_STATUS, 32'h170, 32'h3ff);
    exec(4'h0, 4'h3);
    chk(OFS_MOD_STATUS, 32'h175, 32'h3ff);
    bus(1'b1, OFS_ACK, 32'h1);
    chk(OFS_MOD_STATUS, 32'h0, 32'h300);
    for (int c = 1; c < 10; c++) begin
      exec(4'(c), 4'h1);
      e = {24'h1, ax_code[c]};
      chk(OFS_AXIS_BASE, e, 32'h3ff);
      bus(1'b1, OFS_ACK, 32'h2);
      chk(OFS_AXIS_BASE, 32'h0, 32'h300);
    end
    cmp_cnt(starts, exp_starts);
    exec(4'h0, 4'($urandom_range(2, 1)));
    exp_starts++;
    cmp_cnt(starts, exp_starts);
    for (int i = 0; i < 9; i++) begin
      pos = (i < 4) ? edge_pos[i] : $urandom;
      first_scan <= (i == 8);
      cmd_position <= pos;
      host_command_word <= (i == 7) ? 8'h22 : CMD_MOVE_POS;
      cmd_valid <= 2'b01;
      @(posedge core_clk);
      cmd_valid <= 2'b00;
      first_scan <= 1'b0;
      repeat (2) @(posedge core_clk);
      sp = pos;
      exp_moves += (i < 7 && sp >= -536870912 && sp <= 536870911);
      cmp_cnt(moves, exp_moves);
      e = (i == 8) ? 32'h177 : 32'h0;
      if (i < 7 && !(sp >= -536870912 && sp <= 536870911)) e = 32'h176;
      chk(OFS_AXIS_BASE, e, (e == 0) ? 32'h300 : 32'h3ff);
      bus(1'b1, OFS_ACK, 32'h2);
    end
    for (int i = 0; i < 4; i++) begin
      partner_at_sync <= {1'b0, i[1]};
      continuous_move_sync <= {1'b0, !i[0]};
      jump_sync <= {1'b0, i[0]};
      @(posedge core_clk);
      {continuous_move_sync, jump_sync} <= '0;
      repeat (2) @(posedge core_clk);
      e = i[1] ? 32'h0 : (i[0] ? 32'h18d : 32'h18c);
      chk(OFS_AXIS_BASE, e, (e == 0) ? 32'h300 : 32'h3ff);
      bus(1'b1, OFS_ACK, 32'h2);
    end
    for (int i = 0; i < 6; i++) begin
      flash_fail <= (i == 0);
      ll_halt_write <= (i == 1);
      ll_div_op <= (i == 2 || i == 3);
      ll_divisor <= (i == 2) ? 32'h0 : ($urandom | 32'h1);
      ll_run_start <= (i > 3);
      @(posedge core_clk);
      {flash_fail, ll_halt_write, ll_div_op, ll_run_start} <= '0;
      repeat (5) @(posedge core_clk);
      ll_run_done <= (i == 5);
      @(posedge core_clk);
      ll_run_done <= 1'b0;
      repeat (LLB) @(posedge core_clk);
      e = mod_exp[i];
      chk(OFS_MOD_STATUS, e, (e == 0) ? 32'h300 : 32'h3ff);
      chk(OFS_AXIS_BASE, e & 32'h200, 32'h200);
      exec(4'h0, 4'h1);
      exp_starts += !e[9];
      cmp_cnt(starts, exp_starts);
      bus(1'b1, OFS_ACK, 32'h7);
      chk(OFS_MOD_STATUS, 32'h0, 32'h300);
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
